// ===== timer8_map.vh
// register offsets, field positions, reset values and mode codes
// of the 8-bit waveform timer; included by the timer top module
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH

`define OFS_OUT_MODE_CTRL   8'h24
`define OFS_CLK_FORCE_CTRL  8'h25
`define OFS_COUNT_VALUE     8'h26
`define OFS_CMP_VALUE_A     8'h27
`define OFS_CMP_VALUE_B     8'h28
`define OFS_IRQ_MASK        8'h6e
`define OFS_IRQ_STATUS      8'h35

`define CHAN_A_MSB          7
`define CHAN_A_LSB          6
`define CHAN_B_MSB          5
`define CHAN_B_LSB          4
`define WAVE_LOW_MSB        1
`define WAVE_LOW_LSB        0
`define WAVE_TOP_BIT        3
`define CLK_SEL_MSB         2
`define CLK_SEL_LSB         0

`define FLAG_OVF            0
`define FLAG_MATCH_A        1
`define FLAG_MATCH_B        2

`define RST_BYTE            8'h00
`define CNT_MAX             8'hff
`define CNT_BOTTOM          8'h00

`define MODE_NORMAL         3'h0
`define MODE_PC_FF          3'h1
`define MODE_CLEAR_MATCH    3'h2
`define MODE_FAST_FF        3'h3
`define MODE_PC_CMPA        3'h5
`define MODE_FAST_CMPA      3'h7

`endif

// ===== timer8_waveform_output_control.v
// 8-bit timer/counter with compare outputs and waveform generation
// assumes a single-cycle register port and one free-running clock;
// the tick enable comes from an outside prescaler on the same clock
//
// Our own choice: the plain strobed port.
`include "timer8_map.vh"

module timer8_waveform_output_control (
    // clock and reset
    input  wire       sys_clk,
    input  wire       rstn,
    // prescaled tick from the clock divider
    input  wire       timerTickEnable,
    // register port
    input  wire [7:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrStb,
    input  wire       regRdStb,
    output reg  [7:0] regRdData,
    // compare output pins
    output reg        cmpOutAPin,
    output reg        cmpOutAPinOe,
    output reg        cmpOutBPin,
    output reg        cmpOutBPinOe,
    // interrupt
    output reg        irq
);

    reg  [7:0] modeCtrl_r;
    reg        waveTopBit_r;
    reg  [2:0] clkSel_r;
    reg  [7:0] count_r;
    reg  [7:0] cmpA_r;
    reg  [7:0] cmpB_r;
    reg  [7:0] cmpABuf_r;
    reg  [7:0] cmpBBuf_r;
    reg        countDown_r;
    reg        blockMatch_r;
    reg  [2:0] flags_r;
    reg  [2:0] mask_r;
    reg        outA_r;
    reg        outB_r;

    wire [1:0] chanAOutAction = modeCtrl_r[`CHAN_A_MSB:`CHAN_A_LSB];
    wire [1:0] chanBOutAction = modeCtrl_r[`CHAN_B_MSB:`CHAN_B_LSB];
    wire [2:0] waveModeSel = {waveTopBit_r,
                              modeCtrl_r[`WAVE_LOW_MSB:`WAVE_LOW_LSB]};

    // mode classification
    wire isFast = (waveModeSel == `MODE_FAST_FF) ||
                  (waveModeSel == `MODE_FAST_CMPA);
    wire isPhase = (waveModeSel == `MODE_PC_FF) ||
                   (waveModeSel == `MODE_PC_CMPA);
    wire isCtc = (waveModeSel == `MODE_CLEAR_MATCH);
    wire topIsCmpA = waveTopBit_r | isCtc;
    wire [7:0] topVal = topIsCmpA ? cmpA_r : `CNT_MAX;

    // tick qualifies everything; clock select zero stops the timer
    wire tick = timerTickEnable && (clkSel_r != 3'h0);
    wire atTop = (count_r == topVal);
    wire atBottom = (count_r == `CNT_BOTTOM);
    wire matchA = tick && !blockMatch_r && (count_r == cmpA_r);
    wire matchB = tick && !blockMatch_r && (count_r == cmpB_r);

    wire wrCount = regWrStb && (regAddr == `OFS_COUNT_VALUE);
    wire wrCmpA = regWrStb && (regAddr == `OFS_CMP_VALUE_A);
    wire wrCmpB = regWrStb && (regAddr == `OFS_CMP_VALUE_B);
    wire wrFlags = regWrStb && (regAddr == `OFS_IRQ_STATUS);

    // next counter value and direction
    reg  [7:0] countNxt;
    reg        countDownNxt;
    always @* begin
        countNxt = count_r;
        countDownNxt = countDown_r;
        if (tick) begin
            if (isPhase) begin
                // direction turns at each end with no tick held
                if (!countDown_r && atTop) begin
                    countDownNxt = 1'b1;
                    countNxt = count_r - 8'h01;
                end else if (countDown_r && atBottom) begin
                    countDownNxt = 1'b0;
                    countNxt = count_r + 8'h01;
                end else if (countDown_r) begin
                    countNxt = count_r - 8'h01;
                end else begin
                    countNxt = count_r + 8'h01;
                end
            end else if ((isFast || isCtc) && atTop) begin
                countNxt = `CNT_BOTTOM;
                countDownNxt = 1'b0;
            end else begin
                countNxt = count_r + 8'h01;
                countDownNxt = 1'b0;
            end
        end
    end

    // compare reload moments
    wire reloadNow = tick && ((isPhase && atTop) ||
                              (isFast && atTop));

    // overflow moment
    reg ovfEvent;
    always @* begin
        ovfEvent = 1'b0;
        if (tick) begin
            if (isPhase) begin
                ovfEvent = countDown_r && atBottom;
            end else if (waveModeSel == `MODE_FAST_CMPA) begin
                ovfEvent = atTop;
            end else begin
                ovfEvent = (count_r == `CNT_MAX);
            end
        end
    end

    // flag events; A flags on every match incl. as top
    wire [2:0] flagSet;
    assign flagSet[`FLAG_OVF] = ovfEvent;
    assign flagSet[`FLAG_MATCH_A] = matchA;
    assign flagSet[`FLAG_MATCH_B] = matchB;

    // per-channel waveform next value
    function wavNext;
        input       cur;
        input [1:0] act;
        input       match;
        input       cmpIsTop;
        input       chanA;
        reg         hit;
        begin
            wavNext = cur;
            if (isFast) begin
                hit = match && !(cmpIsTop && act[1]);
                if (act == 2'b01) begin
                    if (chanA && waveTopBit_r && hit) begin
                        wavNext = ~cur;
                    end
                end else if (act[1]) begin
                    if (hit) begin
                        wavNext = act[0];
                    end else if (tick && atTop) begin
                        wavNext = ~act[0];
                    end
                end
            end else if (isPhase) begin
                if (act == 2'b01) begin
                    if (chanA && waveTopBit_r && match) begin
                        wavNext = ~cur;
                    end
                end else if (act[1]) begin
                    if (cmpIsTop) begin
                        if (tick && atTop && !countDown_r) begin
                            wavNext = act[0];
                        end
                    end else if (match) begin
                        wavNext = countDown_r ? ~act[0] : act[0];
                    end
                end
            end else if (match) begin
                case (act)
                    2'b01: wavNext = ~cur;
                    2'b10: wavNext = 1'b0;
                    2'b11: wavNext = 1'b1;
                    default: wavNext = cur;
                endcase
            end
        end
    endfunction

    wire outANxt = wavNext(outA_r, chanAOutAction, matchA,
                           cmpA_r == topVal, 1'b1);
    wire outBNxt = wavNext(outB_r, chanBOutAction, matchB,
                           cmpB_r == topVal, 1'b0);

    // read mux
    reg [7:0] rdNxt;
    always @* begin
        rdNxt = 8'h00;
        if (regAddr == `OFS_OUT_MODE_CTRL) begin
            rdNxt = {modeCtrl_r[7:4], 2'b00, modeCtrl_r[1:0]};
        end else if (regAddr == `OFS_CLK_FORCE_CTRL) begin
            rdNxt = {4'h0, waveTopBit_r, clkSel_r};
        end else if (regAddr == `OFS_COUNT_VALUE) begin
            rdNxt = count_r;
        end else if (regAddr == `OFS_CMP_VALUE_A) begin
            rdNxt = cmpABuf_r;
        end else if (regAddr == `OFS_CMP_VALUE_B) begin
            rdNxt = cmpBBuf_r;
        end else if (regAddr == `OFS_IRQ_MASK) begin
            rdNxt = {5'h00, mask_r};
        end else if (regAddr == `OFS_IRQ_STATUS) begin
            rdNxt = {5'h00, flags_r};
        end
    end

    wire [2:0] flagsNxt = (flags_r & ~(wrFlags ? regWrData[2:0] : 3'h0))
                          | flagSet;
    // mask write takes effect on irq at the same edge as the flag update
    wire       wrMask = regWrStb && (regAddr == `OFS_IRQ_MASK);
    wire [2:0] maskNxt = wrMask ? regWrData[2:0] : mask_r;
    wire bufferedCmp = isFast || isPhase;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            modeCtrl_r <= `RST_BYTE;
            waveTopBit_r <= 1'b0;
            clkSel_r <= 3'h0;
            count_r <= `RST_BYTE;
            cmpA_r <= `RST_BYTE;
            cmpB_r <= `RST_BYTE;
            cmpABuf_r <= `RST_BYTE;
            cmpBBuf_r <= `RST_BYTE;
            countDown_r <= 1'b0;
            blockMatch_r <= 1'b0;
            flags_r <= 3'h0;
            mask_r <= 3'h0;
            outA_r <= 1'b0;
            outB_r <= 1'b0;
            regRdData <= `RST_BYTE;
            cmpOutAPin <= 1'b0;
            cmpOutAPinOe <= 1'b0;
            cmpOutBPin <= 1'b0;
            cmpOutBPinOe <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (regWrStb && regAddr == `OFS_OUT_MODE_CTRL) begin
                modeCtrl_r <= {regWrData[7:4], 2'b00, regWrData[1:0]};
            end
            if (regWrStb && regAddr == `OFS_CLK_FORCE_CTRL) begin
                waveTopBit_r <= regWrData[`WAVE_TOP_BIT];
                clkSel_r <= regWrData[`CLK_SEL_MSB:`CLK_SEL_LSB];
            end
            if (wrMask) begin
                mask_r <= regWrData[2:0];
            end
            // a counter write blocks the match on the next tick
            if (wrCount) begin
                count_r <= regWrData;
                blockMatch_r <= 1'b1;
            end else begin
                count_r <= countNxt;
                countDown_r <= countDownNxt;
                if (tick) begin
                    blockMatch_r <= 1'b0;
                end
            end
            if (wrCmpA) begin
                cmpABuf_r <= regWrData;
            end
            if (wrCmpB) begin
                cmpBBuf_r <= regWrData;
            end
            // immediate in non-PWM modes, else at top
            if (!bufferedCmp || reloadNow) begin
                cmpA_r <= wrCmpA ? regWrData : cmpABuf_r;
                cmpB_r <= wrCmpB ? regWrData : cmpBBuf_r;
            end
            flags_r <= flagsNxt;
            outA_r <= outANxt;
            outB_r <= outBNxt;
            if (regRdStb) begin
                regRdData <= rdNxt;
            end else begin
                regRdData <= `RST_BYTE;
            end
            cmpOutAPin <= outANxt;
            cmpOutBPin <= outBNxt;
            cmpOutAPinOe <= (chanAOutAction != 2'b00);
            cmpOutBPinOe <= (chanBOutAction != 2'b00);
            irq <= |(flagsNxt & maskNxt);
        end
    end

endmodule

// ===== timer8_waveform_chk.sv
// port checker of the 8-bit waveform timer
// bound to the timer top module; sees only its ports
`include "timer8_map.vh"

module timer8_waveform_chk (
    // clock and reset
    input wire       sys_clk,
    input wire       rstn,
    // stimulus side
    input wire       timerTickEnable,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWrStb,
    input wire       regRdStb,
    // design outputs
    input wire [7:0] regRdData,
    input wire       cmpOutAPin,
    input wire       cmpOutAPinOe,
    input wire       cmpOutBPin,
    input wire       cmpOutBPinOe,
    input wire       irq
);
    timeunit 1ns;
    timeprecision 1ns;
    reg  [7:0] ctrlCopy_r;
    wire       ctlWr = regWrStb && (regAddr == `OFS_OUT_MODE_CTRL);
    // copy of the control byte as written
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            ctrlCopy_r <= 8'h00;
        else if (ctlWr)
            ctrlCopy_r <= regWrData;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_rd_idle_zero: assert property (
        !$past(regRdStb) |-> regRdData == 8'h00)
        else $error("read data not zero outside a read");
    chk_ctrl_rsvd_zero: assert property (
        $past(regRdStb && regAddr == `OFS_OUT_MODE_CTRL)
        |-> regRdData[3:2] == 2'b00)
        else $error("reserved control bits read nonzero");
    chk_oe_a_state: assert property (
        !$past(ctlWr) && !$past(ctlWr, 2)
        |-> cmpOutAPinOe == (|ctrlCopy_r[7:6]))
        else $error("pin A enable disagrees with action");
    chk_oe_b_state: assert property (
        !$past(ctlWr) && !$past(ctlWr, 2)
        |-> cmpOutBPinOe == (|ctrlCopy_r[5:4]))
        else $error("pin B enable disagrees with action");
    chk_pin_a_tick: assert property (
        $changed(cmpOutAPin) |-> $past(timerTickEnable) || $past(regWrStb))
        else $error("pin A moved without a tick");
    chk_pin_b_tick: assert property (
        $changed(cmpOutBPin) |-> $past(timerTickEnable) || $past(regWrStb))
        else $error("pin B moved without a tick");
    chk_irq_rise_src: assert property (
        $rose(irq) |-> $past(timerTickEnable)
        || $past(regWrStb && regAddr == `OFS_IRQ_MASK))
        else $error("interrupt rose without tick or mask write");
    chk_irq_fall_src: assert property (
        $fell(irq) |-> $past(regWrStb))
        else $error("interrupt fell without a write");
endmodule

// ===== timer8_waveform_output_control_bench.sv
// self-checking bench of the 8-bit waveform timer
// drives register port and tick itself; binds the port checker
`include "timer8_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    failures++; $display("FAIL %s expected %h seen %h", n, e, g); end end

module timer8_waveform_output_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        timerTickEnable = 1'b0;
    logic  [7:0] regAddr = 8'h00;
    logic  [7:0] regWrData = 8'h00;
    logic        regWrStb = 1'b0;
    logic        regRdStb = 1'b0;
    wire   [7:0] regRdData;
    wire         cmpOutAPin;
    wire         cmpOutAPinOe;
    wire         cmpOutBPin;
    wire         cmpOutBPinOe;
    wire         irq;
    logic  [8:0] notes[$];
    logic  [8:0] note;
    logic        rdSeen = 1'b0;
    logic        pinSmp = 1'b0;
    logic [15:0] lfsr = 16'h094d;
    logic  [7:0] r;
    logic  [7:0] acts[3] = '{8'hf0, 8'ha0, 8'h50};
    logic  [4:0] expP[3] = '{5'h0f, 5'h0a, 5'h0f};
    int          failures = 0;
    int          samples_checked = 0;
    int          i;

    timer8_waveform_output_control DUT (.sys_clk, .rstn, .timerTickEnable,
        .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .cmpOutAPin,
        .cmpOutAPinOe, .cmpOutBPin, .cmpOutBPinOe, .irq);

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    function logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        notes.push_back({1'b0, e});
        @(posedge sys_clk);
        regRdStb <= 1'b0;
    endtask
    // expected {irq, oeB, pinB, oeA, pinA}
    task pins(input logic [4:0] e);
        @(posedge sys_clk);
        pinSmp <= 1'b1;
        notes.push_back({4'h8, e});
        @(posedge sys_clk);
        pinSmp <= 1'b0;
    endtask
    task ticks(input int n);
        @(posedge sys_clk);
        timerTickEnable <= 1'b1;
        repeat (n) @(posedge sys_clk);
        timerTickEnable <= 1'b0;
    endtask
    task done(input int n);
        $display("test %0d complete", n);
    endtask
    task tally_and_finish();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // monitor: oldest note against what the outputs show
    always @(posedge sys_clk) rdSeen <= regRdStb;
    always @(negedge sys_clk) begin
        if (rdSeen || pinSmp) begin
            note = notes.pop_front();
            `CHK(note[8] ? "pins" : "read", note[7:0], note[8] ? {3'h0, irq, cmpOutBPinOe, cmpOutBPin, cmpOutAPinOe, cmpOutAPin} : regRdData)
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("FAIL run length expected end seen timeout");
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(`OFS_OUT_MODE_CTRL, 8'h00);
        rd(8'h99, 8'h00);
        r = rnd();
        wr(`OFS_COUNT_VALUE, r);
        rd(`OFS_COUNT_VALUE, r);
        wr(`OFS_OUT_MODE_CTRL, 8'hfc);
        rd(`OFS_OUT_MODE_CTRL, 8'hf0);
        pins(5'h0a);
        done(1);
        wr(`OFS_CMP_VALUE_A, 8'h03);
        wr(`OFS_CMP_VALUE_B, 8'h05);
        wr(`OFS_CLK_FORCE_CTRL, 8'h01);
        for (i = 0; i < 3; i++) begin
            wr(`OFS_OUT_MODE_CTRL, acts[i]);
            wr(`OFS_COUNT_VALUE, 8'h00);
            ticks(6);
            pins(expP[i]);
        end
        rd(`OFS_IRQ_STATUS, 8'h06);
        wr(`OFS_IRQ_MASK, 8'h02);
        pins(5'h1f);
        wr(`OFS_IRQ_STATUS, 8'h07);
        rd(`OFS_IRQ_STATUS, 8'h00);
        pins(5'h0f);
        done(2);
        wr(`OFS_OUT_MODE_CTRL, 8'h52);
        wr(`OFS_COUNT_VALUE, 8'h00);
        ticks(4);
        rd(`OFS_COUNT_VALUE, 8'h00);
        rd(`OFS_IRQ_STATUS, 8'h02);
        pins(5'h1e);
        wr(`OFS_IRQ_STATUS, 8'h07);
        done(3);
        wr(`OFS_OUT_MODE_CTRL, 8'hb3);
        wr(`OFS_COUNT_VALUE, 8'hfd);
        ticks(3);
        pins(5'h0b);
        ticks(4);
        pins(5'h1a);
        ticks(2);
        pins(5'h1e);
        rd(`OFS_IRQ_STATUS, 8'h07);
        rd(`OFS_COUNT_VALUE, 8'h06);
        wr(`OFS_IRQ_STATUS, 8'h07);
        done(4);
        wr(`OFS_OUT_MODE_CTRL, 8'hf1);
        wr(`OFS_COUNT_VALUE, 8'h00);
        ticks(6);
        pins(5'h1f);
        wr(`OFS_IRQ_STATUS, 8'h07);
        ticks(249);
        rd(`OFS_COUNT_VALUE, 8'hff);
        ticks(256);
        pins(5'h1a);
        rd(`OFS_IRQ_STATUS, 8'h07);
        rd(`OFS_COUNT_VALUE, 8'h01);
        done(5);
        for (i = 0; i < 4 && notes.size() > 0; i++) @(posedge sys_clk);
        if (notes.size() > 0) begin
            failures++;
            $display("FAIL notes expected 0 seen %0d", notes.size());
        end
        tally_and_finish();
    end
endmodule

bind timer8_waveform_output_control timer8_waveform_chk chk (.sys_clk,
    .rstn, .timerTickEnable, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .cmpOutAPin, .cmpOutAPinOe, .cmpOutBPin, .cmpOutBPinOe, .irq);
